// ### pkg/bds_pkg.sv
// Package for the boot display sequencer: opcodes, lengths, carriers
`default_nettype none
package bds_pkg;
	// Opcodes, one byte each
	localparam logic [7:0] OP_EXIT_LO = 8'h00;
	localparam logic [7:0] OP_EXIT_HI = 8'hff;
	localparam logic [7:0] OP_NOP = 8'haa;
	localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
	localparam logic [7:0] OP_LEAVE_WIDE = 8'he9;
	localparam logic [7:0] OP_STATUS_READ = 8'h10;
	localparam logic [7:0] OP_COMMAND_WRITE = 8'h11;
	localparam logic [7:0] OP_DATA_READ = 8'h12;
	localparam logic [7:0] OP_DATA_WRITE = 8'h13;
	localparam logic [7:0] OP_LOAD_LOOP = 8'h20;
	localparam logic [7:0] OP_FETCH_FETCH_ATTRIBUTE_OP = 8'h30;
	localparam logic [7:0] OP_JUMP = 8'h80;
	localparam logic [7:0] OP_DEC_BRANCH = 8'h81;
	// Instruction lengths in bytes
	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_TWO = 3'h2;
	localparam logic [2:0] LEN_FIVE = 3'h5;
	// Values after reset
	localparam logic [31:0] RESET_PC = 32'h00000000;
	localparam logic [7:0] RESET_COUNT = 8'h00;
	// Command/data select levels for the register port
	localparam logic SEL_COMMAND = 1'b0;
	localparam logic SEL_DATA = 1'b1;

	// Decoded instruction class
	typedef enum logic [3:0] {
		BDS_I_EXIT, BDS_I_NOP, BDS_I_ENTER_WIDE, BDS_I_LEAVE_WIDE,
		BDS_I_STATUS_RD, BDS_I_COMMAND_WR, BDS_I_DATA_RD, BDS_I_DATA_WR,
		BDS_I_LOAD_LOOP, BDS_I_FETCH_FETCH_ATTRIBUTE_OP, BDS_I_JUMP, BDS_I_DEC_BRANCH
	} bds_instr_e;

	// Decoder answer
	typedef struct packed {
		bds_instr_e kind;
		logic [2:0] len;
	} bds_decode_s;

	// Flash read request toward the flash reader
	typedef struct packed {
		logic [31:0] addr;
		logic wide;
	} bds_flash_req_s;

	// Internal register port cycle
	typedef struct packed {
		logic write;
		logic select;
		logic [7:0] data;
	} bds_port_req_s;
endpackage
`default_nettype wire

// ### rtl/bds_decoder.sv
// Opcode decoder: class and length of each of the twelve instructions
`timescale 1ns/1ps
`default_nettype none
module bds_decoder
	import bds_pkg::*;
(
	input wire logic [7:0] opcode, // First byte of the instruction
	output bds_pkg::bds_decode_s dec // Class and length
);
	// Pure table; every undefined code also ends the program
	always_comb
	begin
		unique case (opcode)
			OP_EXIT_LO, OP_EXIT_HI: dec = '{BDS_I_EXIT, LEN_ONE};
			OP_NOP: dec = '{BDS_I_NOP, LEN_ONE};
			OP_ENTER_WIDE: dec = '{BDS_I_ENTER_WIDE, LEN_ONE};
			OP_LEAVE_WIDE: dec = '{BDS_I_LEAVE_WIDE, LEN_ONE};
			OP_STATUS_READ: dec = '{BDS_I_STATUS_RD, LEN_TWO};
			OP_COMMAND_WRITE: dec = '{BDS_I_COMMAND_WR, LEN_TWO};
			OP_DATA_READ: dec = '{BDS_I_DATA_RD, LEN_TWO};
			OP_DATA_WRITE: dec = '{BDS_I_DATA_WR, LEN_TWO};
			OP_LOAD_LOOP: dec = '{BDS_I_LOAD_LOOP, LEN_TWO};
			OP_FETCH_FETCH_ATTRIBUTE_OP: dec = '{BDS_I_FETCH_FETCH_ATTRIBUTE_OP, LEN_TWO};
			OP_JUMP: dec = '{BDS_I_JUMP, LEN_FIVE};
			OP_DEC_BRANCH: dec = '{BDS_I_DEC_BRANCH, LEN_FIVE};
			default: dec = '{BDS_I_EXIT, LEN_ONE};
		endcase
	end
endmodule // bds_decoder
`default_nettype wire

// ### rtl/bds_sequencer.sv
// Start-up sequencer: fetches a program from serial flash and runs it until exit
// Functional notes
// - Starts running by itself once reset is released, no host needed.
// - Program and its data bytes are fetched from the external serial flash.
// - After exit the sequencer halts and hands control to the host.
// - Exactly twelve instruction types, chosen by the first opcode byte.
// - Opcode 00h or FFh ends the program.
// - Opcode AAh does nothing and moves to the next byte.
// - Opcode B7h switches flash fetches to four-byte addresses.
// - Opcode E9h returns flash fetches to normal address width.
// - Opcode 10h, two bytes, does a status read on the register port.
// - Opcode 11h, two bytes, writes its second byte as a command.
// - Opcode 12h, two bytes, does a data read on the register port.
// - Opcode 13h, two bytes, writes its second byte as data.
// - Opcode 20h, two bytes, loads its second byte into the repeat counter.
// - Opcode 30h, two bytes, fetches its second byte as the attribute.
// - Opcode 80h, five bytes, jumps to the four-byte address that follows.
// - Opcode 81h, five bytes, decrements the counter then branches unless it reached zero.
// - Status and command cycles use select 0, data cycles select 1.
`timescale 1ns/1ps
`default_nettype none
module bds_sequencer
	import bds_pkg::*;
(
	input wire logic core_clk, // System clock, 250 MHz
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic clkEn, // Clock enable, freezes all state when low
	output bds_pkg::bds_flash_req_s flashReq, // Address and width of next byte read
	output logic flashReqValid, // Flash byte read request, held until taken
	input wire logic flashAck, // Flash returns a byte this cycle
	input wire logic [7:0] flashData, // Byte from flash, valid with flashAck
	output bds_pkg::bds_port_req_s portReq, // Register port cycle
	output logic portReqValid, // Port cycle request, held until taken
	input wire logic portAck, // Port cycle completed this cycle
	input wire logic [7:0] portRdData, // Read data, valid with portAck
	output logic [7:0] portRdLast, // Last byte read from the port
	output logic [7:0] attribute, // Last fetched attribute byte
	output logic [7:0] loopCount, // Repeat counter
	output logic wideAddr, // Flash fetches use four-byte addresses
	output logic running, // Program is executing
	output logic hostOwns // Sequencer done, host owns the device
);
	typedef enum logic [2:0] {
		ST_FETCH, ST_WAIT, ST_EXEC, ST_PORT, ST_HALT
	} bds_state_e;

	bds_state_e state;
	logic [31:0] pc;
	logic [7:0] opByte;
	logic [31:0] operand;
	logic [2:0] byteIdx;
	bds_decode_s dec;
	logic [7:0] decCount;

	bds_decoder uDecoder (
		.opcode(opByte),
		.dec(dec)
	);

	// Counter value after a decrement; wraps 0 to ff
	assign decCount = loopCount - 8'h01;

	// Only port operations need a second pass through ST_PORT
	function automatic logic isPortOp(input bds_instr_e k);
		return k inside {BDS_I_STATUS_RD, BDS_I_COMMAND_WR, BDS_I_DATA_RD, BDS_I_DATA_WR};
	endfunction

	// Main sequencing: fetch bytes of one instruction, then execute it
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ST_FETCH;
			byteIdx <= 3'h0;
			opByte <= 8'h00;
			operand <= 32'h00000000;
		end
		else if (clkEn)
		begin
			unique case (state)
				ST_FETCH:
					state <= ST_WAIT;
				ST_WAIT:
					if (flashAck)
					begin
						if (byteIdx == 3'h0)
							opByte <= flashData;
						else
							operand <= {operand[23:0], flashData}; // Big-endian target
						state <= ST_EXEC;
					end
				ST_EXEC:
					if (byteIdx + 3'h1 < dec.len)
					begin
						byteIdx <= byteIdx + 3'h1;
						state <= ST_FETCH;
					end
					else
					begin
						byteIdx <= 3'h0;
						if (dec.kind == BDS_I_EXIT)
							state <= ST_HALT;
						else if (isPortOp(dec.kind))
							state <= ST_PORT;
						else
							state <= ST_FETCH;
					end
				ST_PORT:
					if (portAck)
						state <= ST_FETCH;
				ST_HALT:
					state <= ST_HALT;
			endcase
		end
	end

	// Fetch pointer: one byte per fetch, targets replace it on jumps
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pc <= RESET_PC;
		else if (clkEn && state == ST_WAIT && flashAck)
			pc <= pc + 32'h1;
		else if (clkEn && state == ST_EXEC && byteIdx + 3'h1 >= dec.len)
		begin
			if (dec.kind == BDS_I_JUMP)
				pc <= operand;
			else if (dec.kind == BDS_I_DEC_BRANCH && decCount != 8'h00)
				pc <= operand;
		end
	end

	// Flash request outputs; narrow mode masks the top address byte
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flashReqValid <= 1'b0;
			flashReq <= '{RESET_PC, 1'b0};
		end
		else if (clkEn)
		begin
			if (state == ST_FETCH)
			begin
				flashReqValid <= 1'b1;
				flashReq <= '{wideAddr ? pc : {8'h00, pc[23:0]}, wideAddr};
			end
			else if (state == ST_WAIT && flashAck)
				flashReqValid <= 1'b0;
		end
	end

	// Address width mode and repeat counter
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wideAddr <= 1'b0;
			loopCount <= RESET_COUNT;
			attribute <= 8'h00;
		end
		else if (clkEn && state == ST_EXEC && byteIdx + 3'h1 >= dec.len)
		begin
			unique case (dec.kind)
				BDS_I_ENTER_WIDE: wideAddr <= 1'b1;
				BDS_I_LEAVE_WIDE: wideAddr <= 1'b0;
				BDS_I_LOAD_LOOP: loopCount <= operand[7:0];
				BDS_I_FETCH_FETCH_ATTRIBUTE_OP: attribute <= operand[7:0];
				BDS_I_DEC_BRANCH: loopCount <= decCount;
				BDS_I_EXIT, BDS_I_NOP, BDS_I_STATUS_RD, BDS_I_COMMAND_WR,
				BDS_I_DATA_RD, BDS_I_DATA_WR, BDS_I_JUMP:
					loopCount <= loopCount;
			endcase
		end
	end

	// Register port cycles; select follows command versus data
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			portReqValid <= 1'b0;
			portReq <= '{1'b0, SEL_COMMAND, 8'h00};
			portRdLast <= 8'h00;
		end
		else if (clkEn)
		begin
			if (state == ST_EXEC && byteIdx + 3'h1 >= dec.len && isPortOp(dec.kind))
			begin
				portReqValid <= 1'b1;
				unique case (dec.kind)
					BDS_I_STATUS_RD: portReq <= '{1'b0, SEL_COMMAND, 8'h00};
					BDS_I_COMMAND_WR: portReq <= '{1'b1, SEL_COMMAND, operand[7:0]};
					BDS_I_DATA_RD: portReq <= '{1'b0, SEL_DATA, 8'h00};
					default: portReq <= '{1'b1, SEL_DATA, operand[7:0]};
				endcase
			end
			else if (state == ST_PORT && portAck)
			begin
				portReqValid <= 1'b0;
				if (!portReq.write)
					portRdLast <= portRdData;
			end
		end
	end

	// Status flags
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			running <= 1'b0;
			hostOwns <= 1'b0;
		end
		else if (clkEn)
		begin
			running <= (state != ST_HALT) && !(state == ST_EXEC && dec.kind == BDS_I_EXIT);
			hostOwns <= (state == ST_HALT) || (state == ST_EXEC && dec.kind == BDS_I_EXIT);
		end
	end

	// Checks
	sequence sJumpDone;
		state == ST_EXEC && byteIdx == 3'h4 && dec.kind == BDS_I_JUMP;
	endsequence
	sequence sDecDone;
		state == ST_EXEC && byteIdx == 3'h4 && dec.kind == BDS_I_DEC_BRANCH;
	endsequence
	// Last byte of any instruction, where its effect is applied
	sequence sLastByte;
		state == ST_EXEC && byteIdx + 3'h1 >= dec.len;
	endsequence

	AST_EXIT_HALTS: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && dec.kind == BDS_I_EXIT |=> state == ST_HALT)
		else $error("exit opcode did not halt");
	AST_HALT_STAYS: assert property (@(posedge core_clk) disable iff (!arst_n)
		state == ST_HALT |=> state == ST_HALT && hostOwns && !running)
		else $error("halt state left or host not given control");
	AST_JUMP_TARGET: assert property (@(posedge core_clk) disable iff (!arst_n)
		sJumpDone and clkEn |=> pc == $past(operand))
		else $error("jump did not load target");
	AST_DEC_BRANCH: assert property (@(posedge core_clk) disable iff (!arst_n)
		sDecDone and (clkEn && decCount == 8'h00) |=> pc == $past(pc))
		else $error("branch taken on zero count");
	AST_DEC_COUNT: assert property (@(posedge core_clk) disable iff (!arst_n)
		sDecDone and clkEn |=> loopCount == $past(loopCount) - 8'h01)
		else $error("counter not decremented");
	AST_WIDE_ON: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && dec.kind == BDS_I_ENTER_WIDE |=> wideAddr)
		else $error("wide mode not entered");
	AST_WIDE_OFF: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && dec.kind == BDS_I_LEAVE_WIDE |=> !wideAddr)
		else $error("wide mode not left");
	AST_PORT_SELECT: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && byteIdx == 3'h1 && dec.kind == BDS_I_DATA_WR
		|=> portReqValid && portReq.select == SEL_DATA && portReq.write
			&& portReq.data == $past(operand[7:0]))
		else $error("port select wrong for data write");
	AST_LOAD_COUNT: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && byteIdx == 3'h1 && dec.kind == BDS_I_LOAD_LOOP
		|=> loopCount == $past(operand[7:0]))
		else $error("repeat counter not loaded");
	AST_FETCH_STEP: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_WAIT && flashAck |=> pc == $past(pc) + 32'h1)
		else $error("pointer did not advance one byte per fetch");

	// Branch and operand effects; a wrong branch would silently loop for ever
	AST_DEC_TAKEN: assert property (@(posedge core_clk) disable iff (!arst_n)
		sDecDone and (clkEn && decCount != 8'h00) |=> pc == $past(operand))
		else $error("branch not taken on nonzero count");
	AST_FALL_THROUGH: assert property (@(posedge core_clk) disable iff (!arst_n)
		sLastByte and (clkEn && dec.kind != BDS_I_JUMP && dec.kind != BDS_I_DEC_BRANCH)
		|=> pc == $past(pc))
		else $error("pointer moved without a fetch or jump");
	AST_FETCH_ATTRIBUTE_OP_LOAD: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && byteIdx == 3'h1 && dec.kind == BDS_I_FETCH_FETCH_ATTRIBUTE_OP
		|=> attribute == $past(operand[7:0]))
		else $error("attribute not fetched");

	// Register port cycles: kind and select of each request, data of writes
	AST_STATUS_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && byteIdx == 3'h1 && dec.kind == BDS_I_STATUS_RD
		|=> portReqValid && !portReq.write && portReq.select == SEL_COMMAND)
		else $error("status read cycle wrong");
	AST_COMMAND_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && byteIdx == 3'h1 && dec.kind == BDS_I_COMMAND_WR
		|=> portReqValid && portReq.write && portReq.select == SEL_COMMAND
			&& portReq.data == $past(operand[7:0]))
		else $error("command write cycle wrong");
	AST_DATA_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_EXEC && byteIdx == 3'h1 && dec.kind == BDS_I_DATA_RD
		|=> portReqValid && !portReq.write && portReq.select == SEL_DATA)
		else $error("data read cycle wrong");
	AST_READ_CAPTURE: assert property (@(posedge core_clk) disable iff (!arst_n)
		clkEn && state == ST_PORT && portAck && !portReq.write |=> portRdLast == $past(portRdData))
		else $error("read data not captured");
	AST_PORT_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
		portReqValid && !(clkEn && portAck) |=> portReqValid && $stable(portReq))
		else $error("port request changed before it was taken");

	// Flash requests stand unchanged until taken, in the width they were issued in
	AST_FLASH_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
		flashReqValid && !(clkEn && flashAck) |=> flashReqValid && $stable(flashReq))
		else $error("flash request changed before it was taken");
	AST_NARROW_MASK: assert property (@(posedge core_clk) disable iff (!arst_n)
		flashReqValid && !flashReq.wide |-> flashReq.addr[31:24] == 8'h00)
		else $error("narrow fetch carries a top address byte");
	AST_REQ_WIDTH: assert property (@(posedge core_clk) disable iff (!arst_n)
		flashReqValid |-> flashReq.wide == wideAddr)
		else $error("fetch width differs from address mode");
	AST_ONE_OWNER: assert property (@(posedge core_clk) disable iff (!arst_n)
		running |-> !hostOwns)
		else $error("sequencer and host both own the device");
endmodule // bds_sequencer
`default_nettype wire

// ### verif/bds_flash_model.sv
// Serial flash partner model holding the start-up program bytes
`timescale 1ns/1ps
`default_nettype none
module bds_flash_model (
	input wire logic core_clk, // System clock
	input wire bds_pkg::bds_flash_req_s flashReq, // Address of the byte wanted
	input wire logic flashReqValid, // Read request standing
	input wire logic [3:0] delay, // Wait cycles before answering
	output logic flashAck, // Byte on flashData
	output logic [7:0] flashData // Program byte
);
	import bds_pkg::*;
	logic [7:0] mem [0:255]; // Only the low address byte selects a cell
	logic [3:0] waitCnt;
	initial
	begin
		flashAck = 1'b0;
		flashData = 8'h00;
		waitCnt = 4'h0;
	end
	// Ack is held while the request stands, so a frozen cycle cannot lose it
	always @(posedge core_clk)
	begin
		if (flashReqValid && (flashAck || waitCnt == delay))
		begin
			flashAck <= 1'b1;
			flashData <= mem[flashReq.addr[7:0]];
		end
		else
		begin
			flashAck <= 1'b0;
			flashData <= ~flashData; // Idle bus never repeats the last byte
		end
		waitCnt <= flashReqValid ? waitCnt + 4'h1 : 4'h0;
	end
endmodule // bds_flash_model
`default_nettype wire

// ### verif/boot_display_sequencer_tb.sv
// Self-checking bench for the boot display sequencer
`timescale 1ns/1ps
`default_nettype none
`define BDS_CHK(w, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("Error %s expected %h seen %h", w, e, g); \
		end \
	end
module boot_display_sequencer_tb;
	import bds_pkg::*;
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] arg;
		logic [2:0] n; // Flash fetches including the exit
		logic port;
		logic wr;
		logic sel;
		logic [7:0] lc;
		logic [7:0] at;
		logic wide;
	} bds_row_s;
	logic core_clk, arst_n, clkEn, flashAck, portAck, flashReqValid, portReqValid;
	logic wideAddr, running, hostOwns;
	logic [7:0] flashData, portRdData, portRdLast, attribute, loopCount, rdVal;
	logic [3:0] delay;
	logic [31:0] lastAddr;
	logic [31:0] seenAddr [0:255];
	bds_flash_req_s flashReq;
	bds_port_req_s portReq;
	bds_port_req_s portLog [$];
	int compares, n_mismatch, nAck;
	// One instruction at address 0, exit after it
	bds_row_s rows [10] = '{
		'{OP_STATUS_READ, 8'h00, 3'h3, 1'b1, 1'b0, SEL_COMMAND, 8'h00, 8'h00, 1'b0},
		'{OP_COMMAND_WRITE, 8'h5c, 3'h3, 1'b1, 1'b1, SEL_COMMAND, 8'h00, 8'h00, 1'b0},
		'{OP_DATA_READ, 8'h00, 3'h3, 1'b1, 1'b0, SEL_DATA, 8'h00, 8'h00, 1'b0},
		'{OP_DATA_WRITE, 8'ha7, 3'h3, 1'b1, 1'b1, SEL_DATA, 8'h00, 8'h00, 1'b0},
		'{OP_LOAD_LOOP, 8'h3c, 3'h3, 1'b0, 1'b0, 1'b0, 8'h3c, 8'h00, 1'b0},
		'{OP_FETCH_FETCH_ATTRIBUTE_OP, 8'h96, 3'h3, 1'b0, 1'b0, 1'b0, 8'h00, 8'h96, 1'b0},
		'{OP_NOP, 8'h00, 3'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0},
		'{OP_ENTER_WIDE, 8'h00, 3'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1},
		'{OP_EXIT_HI, 8'h13, 3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0},
		'{OP_EXIT_LO, 8'h11, 3'h1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0}
	};
	bds_sequencer bds_sequencer_i (.core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
		.flashReq(flashReq), .flashReqValid(flashReqValid), .flashAck(flashAck),
		.flashData(flashData), .portReq(portReq), .portReqValid(portReqValid),
		.portAck(portAck), .portRdData(portRdData), .portRdLast(portRdLast),
		.attribute(attribute), .loopCount(loopCount), .wideAddr(wideAddr),
		.running(running), .hostOwns(hostOwns));
	bds_flash_model bds_flash_model_i (.core_clk(core_clk), .flashReq(flashReq),
		.flashReqValid(flashReqValid), .delay(delay), .flashAck(flashAck),
		.flashData(flashData));
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Register port answers at once; taken cycles and fetches are logged
	always @(posedge core_clk)
	begin
		portAck <= portReqValid;
		portRdData <= portReqValid ? rdVal : ~portRdData;
		if (portReqValid && portAck && clkEn)
			portLog.push_back(portReq);
		if (flashReqValid && flashAck && clkEn)
		begin
			nAck++;
			lastAddr = flashReq.addr;
			seenAddr[flashReq.addr[7:0]] = flashReq.addr;
		end
	end
	task automatic end_of_test();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Empty program store reads as exit everywhere
	task automatic clr();
		for (int j = 0; j < 256; j++)
		begin
			bds_flash_model_i.mem[j] = 8'h00;
			seenAddr[j] = 32'hffffffff;
		end
	endtask
	// First byte sits in the highest of the n low bytes of w
	task automatic prog(input logic [7:0] a, input logic [39:0] w, input int n);
		for (int j = 0; j < n; j++)
			bds_flash_model_i.mem[a + 8'(j)] = w[8 * (n - 1 - j) +: 8];
	endtask
	task automatic start(input logic [3:0] d);
		@(posedge core_clk);
		delay <= d;
		arst_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		nAck = 0;
		portLog.delete();
		`BDS_CHK("running in reset", 1'b0, running)
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		`BDS_CHK("self start", 1'b1, running & flashReqValid)
		`BDS_CHK("first fetch", RESET_PC, flashReq.addr)
	endtask
	task automatic finish_run();
		int k;
		k = 0;
		while (hostOwns !== 1'b1 && k < 3000)
		begin
			@(posedge core_clk);
			k++;
		end
		#1;
		if (k == 3000)
		begin
			n_mismatch++;
			end_of_test();
		end
		`BDS_CHK("running", 1'b0, running)
	endtask
	initial
	begin
		arst_n = 1'b0;
		clkEn = 1'b1;
		delay = 4'h0;
		rdVal = 8'h00;
		portAck = 1'b0;
		portRdData = 8'h00;
		compares = 0;
		n_mismatch = 0;
		nAck = 0;
		for (int i = 0; i < 10; i++)
		begin
			rdVal = 8'h60 + 8'(i);
			clr();
			prog(8'h00, {24'h0, rows[i].op, rows[i].arg}, 2);
			start(4'h0);
			finish_run();
			`BDS_CHK("fetches", int'(rows[i].n), nAck)
			`BDS_CHK("lastAddr", 32'(rows[i].n) - 32'h1, lastAddr)
			`BDS_CHK("port cycles", int'(rows[i].port), portLog.size())
			if (rows[i].port)
			begin
				`BDS_CHK("write", rows[i].wr, portLog[0].write)
				`BDS_CHK("select", rows[i].sel, portLog[0].select)
				if (rows[i].wr)
					`BDS_CHK("data", rows[i].arg, portLog[0].data)
			end
			`BDS_CHK("rdLast", (rows[i].port && !rows[i].wr) ? rdVal : 8'h00, portRdLast)
			`BDS_CHK("loopCount", rows[i].lc, loopCount)
			`BDS_CHK("attribute", rows[i].at, attribute)
			`BDS_CHK("wideAddr", rows[i].wide, wideAddr)
			`BDS_CHK("req wide", rows[i].wide, flashReq.wide)
		end
		// Jumps across wide and narrow addressing, slow flash
		clr();
		prog(8'h00, 40'hb7, 1);
		prog(8'h01, 40'h8001000010, 5);
		prog(8'h10, 40'he9, 1);
		prog(8'h11, 40'h8002000020, 5);
		start(4'h1);
		finish_run();
		`BDS_CHK("jump fetches", 13, nAck)
		`BDS_CHK("wide target", 32'h01000010, seenAddr[8'h10])
		`BDS_CHK("narrow target", 32'h00000020, seenAddr[8'h20])
		`BDS_CHK("skipped byte", 32'hffffffff, seenAddr[8'h06])
		`BDS_CHK("wide off", 1'b0, wideAddr)
		// Counted loop of three passes, clock enable dropped mid-run
		clr();
		prog(8'h00, 40'h2003, 2);
		prog(8'h02, 40'h8100000002, 5);
		prog(8'h07, 40'h1355, 2);
		start(4'h3);
		@(posedge core_clk);
		clkEn <= 1'b0;
		repeat (6) @(posedge core_clk);
		clkEn <= 1'b1;
		finish_run();
		`BDS_CHK("loop fetches", 20, nAck)
		`BDS_CHK("loop count", 8'h00, loopCount)
		`BDS_CHK("loop exit", 32'h00000009, lastAddr)
		`BDS_CHK("loop port", {1'b1, SEL_DATA, 8'h55}, portLog[0])
		// Reset in the middle of an endless jump
		clr();
		prog(8'h00, 40'h8000000000, 5);
		start(4'h0);
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b0;
		#1;
		`BDS_CHK("reset idle", 3'h0, {running, flashReqValid, hostOwns})
		end_of_test();
	end
endmodule // boot_display_sequencer_tb
`default_nettype wire
